// *** hw/uart_status_regs.sv ***
// Line status, modem status, special function and divisor registers
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module uart_status_regs (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire uart_status_pkg::axil_req_t axil_req_i,
    output uart_status_pkg::axil_rsp_t axil_rsp_o,
    input wire logic [7:0] rx_fifo_fill_count_i,
    input wire logic [7:0] tx_fifo_fill_count_i,
    input wire logic [7:0] line_status_err_count_i,
    input wire logic [7:0] sample_clock_setting_i,
    input wire uart_status_pkg::line_events_t line_events_i,
    input wire logic cts_i,
    input wire logic dsr_i,
    input wire logic ri_i,
    input wire logic dcd_i,
    input wire logic dtr_manual_i,
    output logic [15:0] divisor_o,
    output logic [7:0] line_control_o,
    output logic force_tx_o,
    output logic auto_dsr_dtr_en_o,
    output logic enhanced_mode_o,
    output logic tx_allowed_o,
    output logic dtr_o
);
    // ========================================================
    // Storage
    logic [7:0] div_low_q;
    logic [7:0] div_high_q;
    logic [7:0] line_ctrl_q;
    logic [7:0] special_q;
    logic [7:0] line_status_q;
    logic [7:0] line_status_d;

    // ========================================================
    // Modem inputs
    uart_status_pkg::modem_lines_t modem_raw;
    uart_status_pkg::modem_lines_t modem_sync;
    uart_status_pkg::modem_lines_t modem_level;
    uart_status_pkg::modem_lines_t modem_flag;
    logic modem_clear;

    assign modem_raw = {dcd_i, ri_i, dsr_i, cts_i};

    modem_level_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .raw_i(modem_raw),
        .sync_o(modem_sync)
    );

    modem_change_flags u_flags (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .sync_i(modem_sync),
        .clear_i(modem_clear),
        .level_o(modem_level),
        .flag_o(modem_flag)
    );

    wire [7:0] modem_status = {modem_level, modem_flag};

    // ========================================================
    // Line status snapshot, one cycle behind the datapath
    always_comb begin
        line_status_d = uart_status_pkg::RST_BYTE;
        line_status_d[uart_status_pkg::LS_RX_AVAIL] =
            (rx_fifo_fill_count_i != 8'h00);
        line_status_d[uart_status_pkg::LS_OVERRUN] =
            line_events_i.overrun;
        line_status_d[uart_status_pkg::LS_PARITY] =
            line_events_i.parity_err;
        line_status_d[uart_status_pkg::LS_FRAMING] =
            line_events_i.framing_err;
        line_status_d[uart_status_pkg::LS_BREAK] =
            line_events_i.break_det;
        line_status_d[uart_status_pkg::LS_THR_EMPTY] =
            line_events_i.thr_empty;
        line_status_d[uart_status_pkg::LS_TSR_EMPTY] =
            line_events_i.tsr_empty;
        line_status_d[uart_status_pkg::LS_FIFO_ERR] =
            line_events_i.fifo_err;
    end

    // ========================================================
    // AXI4-Lite write channel
    logic aw_held_q;
    logic w_held_q;
    logic [5:0] aw_idx_q;
    logic [7:0] w_byte_q;
    logic w_lane0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    wire aw_take = axil_req_i.awvalid & ~aw_held_q & ~bvalid_q;
    wire w_take = axil_req_i.wvalid & ~w_held_q & ~bvalid_q;
    wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;
    wire b_done = bvalid_q & axil_req_i.bready;

    wire dlab = line_ctrl_q[uart_status_pkg::LC_DIV_LATCH];

    wire wr_div_low = (aw_idx_q == uart_status_pkg::IDX_DIV_LOW) & dlab;
    wire wr_div_high = (aw_idx_q == uart_status_pkg::IDX_DIV_HIGH) & dlab;
    wire wr_line_ctrl = (aw_idx_q == uart_status_pkg::IDX_LINE_CTRL);
    wire wr_special = (aw_idx_q == uart_status_pkg::IDX_SPECIAL_FUNC);
    // Read-only status offsets, and the divisor offsets with the latch off, accept the write but store nothing
    wire wr_readonly = (aw_idx_q == uart_status_pkg::IDX_LINE_STATUS) |
        (aw_idx_q == uart_status_pkg::IDX_MODEM_STATUS) |
        (aw_idx_q == uart_status_pkg::IDX_RX_COUNT_SEL) |
        (aw_idx_q == uart_status_pkg::IDX_TX_COUNT_SEL) |
        (aw_idx_q == uart_status_pkg::IDX_DIV_LOW) |
        (aw_idx_q == uart_status_pkg::IDX_DIV_HIGH);
    wire wr_mapped = wr_div_low | wr_div_high | wr_line_ctrl |
        wr_special | wr_readonly;
    wire wr_commit = wr_fire & w_lane0_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_held_q <= 1'b0;
            aw_idx_q <= 6'h00;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_idx_q <= axil_req_i.awaddr[uart_status_pkg::ADDR_W-1:2];
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            w_held_q <= 1'b0;
            w_byte_q <= uart_status_pkg::RST_BYTE;
            w_lane0_q <= 1'b0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
            w_byte_q <= axil_req_i.wdata[7:0];
            w_lane0_q <= axil_req_i.wstrb[0];
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bvalid_q <= 1'b0;
            bresp_q <= uart_status_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? uart_status_pkg::RESP_OKAY :
                uart_status_pkg::RESP_SLVERR;
        end else if (b_done) begin
            bvalid_q <= 1'b0;
        end
    end

    // ========================================================
    // Writable registers
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_low_q <= uart_status_pkg::RST_BYTE;
            div_high_q <= uart_status_pkg::RST_BYTE;
            line_ctrl_q <= uart_status_pkg::RST_BYTE;
            special_q <= uart_status_pkg::RST_BYTE;
        end else if (wr_commit) begin
            if (wr_div_low) begin
                div_low_q <= w_byte_q;
            end
            if (wr_div_high) begin
                div_high_q <= w_byte_q;
            end
            if (wr_line_ctrl) begin
                line_ctrl_q <= w_byte_q;
            end
            if (wr_special) begin
                special_q <= w_byte_q &
                    uart_status_pkg::SF_WRITE_MASK;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            line_status_q <= uart_status_pkg::RST_BYTE;
        end else begin
            line_status_q <= line_status_d;
        end
    end

    // ========================================================
    // AXI4-Lite read channel
    logic rvalid_q;
    logic [7:0] rdata_q;
    logic [1:0] rresp_q;

    wire ar_take = axil_req_i.arvalid & ~rvalid_q;
    wire [5:0] ar_idx = axil_req_i.araddr[uart_status_pkg::ADDR_W-1:2];

    wire rd_div_low = (ar_idx == uart_status_pkg::IDX_DIV_LOW) & dlab;
    wire rd_div_high = (ar_idx == uart_status_pkg::IDX_DIV_HIGH) & dlab;
    // Data and interrupt registers live elsewhere; read as zero here
    wire rd_data_slot = ((ar_idx == uart_status_pkg::IDX_DIV_LOW) |
        (ar_idx == uart_status_pkg::IDX_DIV_HIGH)) & ~dlab;
    wire rd_line_ctrl = (ar_idx == uart_status_pkg::IDX_LINE_CTRL);
    wire rd_line_status = (ar_idx == uart_status_pkg::IDX_LINE_STATUS);
    wire rd_modem = (ar_idx == uart_status_pkg::IDX_MODEM_STATUS);
    wire rd_special = (ar_idx == uart_status_pkg::IDX_SPECIAL_FUNC);
    wire rd_rx_sel = (ar_idx == uart_status_pkg::IDX_RX_COUNT_SEL);
    wire rd_tx_sel = (ar_idx == uart_status_pkg::IDX_TX_COUNT_SEL);
    wire rd_mapped = rd_div_low | rd_div_high | rd_data_slot |
        rd_line_ctrl | rd_line_status | rd_modem | rd_special |
        rd_rx_sel | rd_tx_sel;

    wire [7:0] rx_sel_val = special_q[uart_status_pkg::SF_RX_SEL] ?
        line_status_err_count_i : rx_fifo_fill_count_i;
    wire [7:0] tx_sel_val = special_q[uart_status_pkg::SF_TX_SEL] ?
        tx_fifo_fill_count_i : sample_clock_setting_i;

    wire [7:0] rd_byte =
        ({8{rd_div_low}} & div_low_q) |
        ({8{rd_div_high}} & div_high_q) |
        ({8{rd_line_ctrl}} & line_ctrl_q) |
        ({8{rd_line_status}} & line_status_q) |
        ({8{rd_modem}} & modem_status) |
        ({8{rd_special}} & special_q) |
        ({8{rd_rx_sel}} & rx_sel_val) |
        ({8{rd_tx_sel}} & tx_sel_val);

    // Flags clear in the cycle the read is taken, same cycle as capture
    assign modem_clear = ar_take & rd_modem;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= uart_status_pkg::RST_BYTE;
            rresp_q <= uart_status_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_byte;
            rresp_q <= rd_mapped ? uart_status_pkg::RESP_OKAY :
                uart_status_pkg::RESP_SLVERR;
        end else if (axil_req_i.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ========================================================
    // Bus outputs
    assign axil_rsp_o.awready = ~aw_held_q & ~bvalid_q;
    assign axil_rsp_o.wready = ~w_held_q & ~bvalid_q;
    assign axil_rsp_o.bvalid = bvalid_q;
    assign axil_rsp_o.bresp = bresp_q;
    assign axil_rsp_o.arready = ~rvalid_q;
    assign axil_rsp_o.rvalid = rvalid_q;
    assign axil_rsp_o.rdata = {24'h000000, rdata_q};
    assign axil_rsp_o.rresp = rresp_q;

    // ========================================================
    // Controls toward the channel datapath
    assign divisor_o = {div_high_q, div_low_q};
    assign line_control_o = line_ctrl_q;
    assign force_tx_o = special_q[uart_status_pkg::SF_FORCE_TX];
    assign auto_dsr_dtr_en_o = special_q[uart_status_pkg::SF_AUTO_DSR_DTR];
    assign enhanced_mode_o = special_q[uart_status_pkg::SF_ENHANCED];

    // Forcing overrides any flow control hold on the transmitter
    assign tx_allowed_o = force_tx_o | ~auto_dsr_dtr_en_o |
        modem_level[uart_status_pkg::MS_DSR];
    // Receiver backs off the far end as its FIFO nears full
    assign dtr_o = auto_dsr_dtr_en_o ?
        (rx_fifo_fill_count_i < uart_status_pkg::RX_NEAR_FULL) :
        dtr_manual_i;

endmodule

// *** hw/uart_status_pkg.sv ***
// Shared constants, register indices and bus carriers for the status block
package uart_status_pkg;

    // ========================================================
    // Register indices (byte address is four times the index)
    localparam logic [5:0] IDX_DIV_LOW = 6'h00;
    localparam logic [5:0] IDX_DIV_HIGH = 6'h01;
    localparam logic [5:0] IDX_LINE_CTRL = 6'h03;
    localparam logic [5:0] IDX_LINE_STATUS = 6'h05;
    localparam logic [5:0] IDX_MODEM_STATUS = 6'h06;
    localparam logic [5:0] IDX_SPECIAL_FUNC = 6'h07;
    localparam logic [5:0] IDX_RX_COUNT_SEL = 6'h15;
    localparam logic [5:0] IDX_TX_COUNT_SEL = 6'h16;

    localparam int ADDR_W = 8;

    // ========================================================
    // Field positions
    localparam int LC_DIV_LATCH = 7;
    localparam int LS_RX_AVAIL = 0;
    localparam int LS_OVERRUN = 1;
    localparam int LS_PARITY = 2;
    localparam int LS_FRAMING = 3;
    localparam int LS_BREAK = 4;
    localparam int LS_THR_EMPTY = 5;
    localparam int LS_TSR_EMPTY = 6;
    localparam int LS_FIFO_ERR = 7;
    localparam int MS_CTS = 0;
    localparam int MS_DSR = 1;
    localparam int MS_RI = 2;
    localparam int MS_DCD = 3;
    localparam int MS_LEVEL_LSB = 4;
    localparam int SF_FORCE_TX = 0;
    localparam int SF_AUTO_DSR_DTR = 1;
    localparam int SF_ENHANCED = 5;
    localparam int SF_RX_SEL = 6;
    localparam int SF_TX_SEL = 7;
    localparam logic [7:0] SF_WRITE_MASK = 8'he3;

    // ========================================================
    // Reset values and thresholds
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RX_NEAR_FULL = 8'h38;

    // ========================================================
    // AXI4-Lite response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;

    typedef struct packed {
        logic overrun;
        logic parity_err;
        logic framing_err;
        logic break_det;
        logic thr_empty;
        logic tsr_empty;
        logic fifo_err;
    } line_events_t;

    // Modem lines in flag order: cts, dsr, ri, dcd at bits 0..3
    typedef logic [3:0] modem_lines_t;

endpackage

// *** hw/modem_level_sync.sv ***
// Two-stage synchroniser for the four modem input lines
`timescale 1ns/100ps
module modem_level_sync (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire uart_status_pkg::modem_lines_t raw_i,
    output uart_status_pkg::modem_lines_t sync_o
);
    // ========================================================
    // Synchroniser chain
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            logic meta_q;
            logic stable_q;
            always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_q <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q <= raw_i[g];
                    stable_q <= meta_q;
                end
            end
            assign sync_o[g] = stable_q;
        end
    endgenerate
endmodule

// *** hw/modem_change_flags.sv ***
// Present levels and sticky change flags for the modem inputs
`timescale 1ns/100ps
module modem_change_flags (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire uart_status_pkg::modem_lines_t sync_i,
    input wire logic clear_i,
    output uart_status_pkg::modem_lines_t level_o,
    output uart_status_pkg::modem_lines_t flag_o
);
    // ========================================================
    // Per-line change detection
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_line
            logic level_q;
            logic flag_q;
            logic flag_d;
            logic hit;
            // Ring indicator only counts a rising edge
            if (g == uart_status_pkg::MS_RI) begin : g_rise
                assign hit = sync_i[g] & ~level_q;
            end else begin : g_any
                assign hit = sync_i[g] ^ level_q;
            end
            // A change seen during the clearing read stays flagged
            assign flag_d = (flag_q & ~clear_i) | hit;
            always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    level_q <= 1'b0;
                    flag_q <= 1'b0;
                end else begin
                    level_q <= sync_i[g];
                    flag_q <= flag_d;
                end
            end
            assign level_o[g] = level_q;
            assign flag_o[g] = flag_q;
        end
    endgenerate
endmodule

// *** tb/uart_status_regs_checker.sv ***
// Assertion checker for the status register block
`timescale 1ns/100ps
module uart_status_regs_checker (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire uart_status_pkg::axil_req_t axil_req_i,
    input wire uart_status_pkg::axil_rsp_t axil_rsp_o,
    input wire logic [7:0] rx_fifo_fill_count_i,
    input wire logic dsr_i,
    input wire logic [15:0] divisor_o,
    input wire logic force_tx_o,
    input wire logic auto_dsr_dtr_en_o,
    input wire logic enhanced_mode_o,
    input wire logic tx_allowed_o,
    input wire logic dtr_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    // ==========================================================
    // Bus answers
    property p_wr_answer;
        axil_req_i.awvalid && axil_rsp_o.awready && axil_req_i.wvalid &&
            axil_rsp_o.wready |-> ##[1:2] axil_rsp_o.bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write not answered");
    property p_rd_answer;
        axil_req_i.arvalid && axil_rsp_o.arready |=> axil_rsp_o.rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    property p_rd_hold;
        axil_rsp_o.rvalid && !axil_req_i.rready |=>
            axil_rsp_o.rvalid && $stable(axil_rsp_o.rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data dropped early");
    // ==========================================================
    // Settings change only with a committed write
    property p_div_write_only;
        $changed(divisor_o) |-> $rose(axil_rsp_o.bvalid);
    endproperty
    a_div_write_only: assert property (p_div_write_only)
        else $error("divisor changed without write");
    property p_special_write_only;
        $changed({force_tx_o, auto_dsr_dtr_en_o, enhanced_mode_o}) |->
            $rose(axil_rsp_o.bvalid);
    endproperty
    a_special_write_only: assert property (p_special_write_only)
        else $error("special bits changed without write");
    // ==========================================================
    // Flow control outputs
    property p_force;
        force_tx_o || !auto_dsr_dtr_en_o |-> tx_allowed_o;
    endproperty
    a_force: assert property (p_force)
        else $error("transmit blocked while forced or auto off");
    property p_dsr_flow;
        (!dsr_i)[*4] ##0 (auto_dsr_dtr_en_o && !force_tx_o) |->
            !tx_allowed_o;
    endproperty
    a_dsr_flow: assert property (p_dsr_flow)
        else $error("transmit allowed with set-ready low");
    property p_dtr_auto;
        auto_dsr_dtr_en_o |-> dtr_o == (rx_fifo_fill_count_i < 8'h38);
    endproperty
    a_dtr_auto: assert property (p_dtr_auto)
        else $error("terminal-ready wrong in auto mode");
endmodule

bind uart_status_regs uart_status_regs_checker u_uart_status_regs_checker (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .axil_req_i(axil_req_i),
    .axil_rsp_o(axil_rsp_o),
    .rx_fifo_fill_count_i(rx_fifo_fill_count_i),
    .dsr_i(dsr_i),
    .divisor_o(divisor_o),
    .force_tx_o(force_tx_o),
    .auto_dsr_dtr_en_o(auto_dsr_dtr_en_o),
    .enhanced_mode_o(enhanced_mode_o),
    .tx_allowed_o(tx_allowed_o),
    .dtr_o(dtr_o)
);

// *** tb/modem_partner.sv ***
// Behavioural remote modem driving the four status lines
`timescale 1ns/100ps
module modem_partner (
    input wire logic clk_sys_i,
    input wire uart_status_pkg::modem_lines_t lines_i,
    output logic cts_o,
    output logic dsr_o,
    output logic ri_o,
    output logic dcd_o
);
    // ==========================================================
    // Lines move just after an edge, unrelated to bus traffic
    // Lines settle at the first edge, long before reset is released
    always @(posedge clk_sys_i) begin
        {dcd_o, ri_o, dsr_o, cts_o} <= lines_i;
    end
endmodule

// *** tb/tb_top.sv ***
// Self-checking testbench for the status register block
`timescale 1ns/100ps
module tb_top;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    uart_status_pkg::axil_req_t req = '{bready: 1'b1, rready: 1'b1,
                                        default: '0};
    uart_status_pkg::axil_rsp_t rsp;
    uart_status_pkg::line_events_t ev = '0;
    uart_status_pkg::modem_lines_t modem_cmd = 4'h0;
    logic [7:0] rx_cnt = 8'h00;
    logic [7:0] tx_cnt = 8'h33;
    logic [7:0] err_cnt = 8'h22;
    logic [7:0] smp_clk = 8'h44;
    logic cts, dsr, ri, dcd, force_tx, auto_en, enh, tx_allowed, dtr;
    logic dtr_manual = 1'b0;
    logic [15:0] divisor;
    logic [7:0] line_control;
    int num_errors = 0;
    int cmp_count = 0;
    localparam logic [1:0] OK = uart_status_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = uart_status_pkg::RESP_SLVERR;

    always #5 clk_sys_i = ~clk_sys_i;

    modem_partner u_modem_partner (.clk_sys_i(clk_sys_i),
        .lines_i(modem_cmd), .cts_o(cts), .dsr_o(dsr), .ri_o(ri),
        .dcd_o(dcd));

    uart_status_regs u_uart_status_regs (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .axil_req_i(req), .axil_rsp_o(rsp),
        .rx_fifo_fill_count_i(rx_cnt), .tx_fifo_fill_count_i(tx_cnt),
        .line_status_err_count_i(err_cnt),
        .sample_clock_setting_i(smp_clk), .line_events_i(ev),
        .cts_i(cts), .dsr_i(dsr), .ri_i(ri), .dcd_i(dcd),
        .dtr_manual_i(dtr_manual), .divisor_o(divisor),
        .line_control_o(line_control), .force_tx_o(force_tx),
        .auto_dsr_dtr_en_o(auto_en), .enhanced_mode_o(enh),
        .tx_allowed_o(tx_allowed), .dtr_o(dtr));

    // ==========================================================
    // Shared tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Ready lines stay high, so a task may follow another at once
    task automatic axi_wr(input logic [5:0] idx, input logic [7:0] d,
                          input logic [1:0] er);
        req.awaddr <= {idx, 2'b00};
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (!((!req.awvalid || rsp.awready) &&
                     (!req.wvalid || rsp.wready)));
        do @(posedge clk_sys_i); while (!rsp.bvalid);
        check8({6'h0, rsp.bresp}, {6'h0, er});
    endtask

    task automatic axi_rd(input logic [5:0] idx, input logic [7:0] exp,
                          input logic [1:0] er);
        req.araddr <= {idx, 2'b00};
        req.arvalid <= 1'b1;
        do @(posedge clk_sys_i); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge clk_sys_i); while (!rsp.rvalid);
        check8(rsp.rdata[7:0], exp);
        check8({6'h0, rsp.rresp}, {6'h0, er});
        check8({7'h0, |rsp.rdata[31:8]}, 8'h00);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        axi_rd(6'h05, 8'h00, OK);
        axi_rd(6'h06, 8'h00, OK);
        axi_rd(6'h07, 8'h00, OK);
        check8(divisor[7:0], 8'h00);
    endtask

    task automatic t_line;
        for (int i = 0; i < 8; i++) begin
            rx_cnt <= (i == 0) ? 8'h11 : 8'h00;
            ev <= (i == 0) ? 7'h00 : 7'h40 >> (i - 1);
            cyc(2);
            axi_rd(6'h05, 8'h01 << i, OK);
        end
        axi_wr(6'h05, 8'h00, OK);
        axi_rd(6'h05, 8'h80, OK);
        ev <= '0;
        rx_cnt <= 8'h11;
    endtask

    task automatic t_modem;
        modem_cmd <= 4'hf;
        cyc(6);
        axi_rd(6'h06, 8'hff, OK);
        axi_rd(6'h06, 8'hf0, OK);
        modem_cmd <= 4'h6;
        cyc(6);
        axi_rd(6'h06, 8'h69, OK);
        modem_cmd <= 4'h2;
        cyc(6);
        axi_rd(6'h06, 8'h20, OK);
        // Change lands on the very edge that takes the clearing read
        modem_cmd <= 4'h3;
        cyc(3);
        axi_rd(6'h06, 8'h20, OK);
        axi_rd(6'h06, 8'h31, OK);
    endtask

    task automatic t_special;
        axi_wr(6'h07, 8'hff, OK);
        axi_rd(6'h07, 8'he3, OK);
        check8({5'h0, force_tx, auto_en, enh}, 8'h07);
        axi_rd(6'h15, 8'h22, OK);
        axi_rd(6'h16, 8'h33, OK);
        axi_wr(6'h07, 8'h02, OK);
        axi_rd(6'h15, 8'h11, OK);
        axi_rd(6'h16, 8'h44, OK);
        check8({7'h0, tx_allowed}, 8'h01);
        modem_cmd <= 4'h0;
        cyc(5);
        check8({7'h0, tx_allowed}, 8'h00);
        check8({7'h0, dtr}, 8'h01);
        rx_cnt <= 8'h38;
        cyc(2);
        check8({7'h0, dtr}, 8'h00);
        axi_wr(6'h07, 8'h03, OK);
        check8({7'h0, tx_allowed}, 8'h01);
        axi_wr(6'h07, 8'h00, OK);
        dtr_manual <= 1'b1;
        cyc(2);
        check8({6'h0, dtr, enh}, 8'h02);
    endtask

    task automatic t_divisor;
        axi_wr(6'h03, 8'h80, OK);
        check8(line_control, 8'h80);
        axi_wr(6'h00, 8'h5a, OK);
        axi_wr(6'h01, 8'ha5, OK);
        axi_rd(6'h00, 8'h5a, OK);
        axi_rd(6'h01, 8'ha5, OK);
        check8(divisor[15:8], 8'ha5);
        axi_wr(6'h03, 8'h00, OK);
        axi_rd(6'h00, 8'h00, OK);
        axi_wr(6'h00, 8'h77, OK);
        check8(divisor[7:0], 8'h5a);
        axi_wr(6'h3f, 8'h00, ERR);
    endtask

    // Slow reader: the answer must stand until rready returns
    task automatic t_stall;
        req.rready <= 1'b0;
        req.araddr <= {uart_status_pkg::IDX_LINE_STATUS, 2'b00};
        req.arvalid <= 1'b1;
        do cyc(1); while (!rsp.arready);
        req.arvalid <= 1'b0;
        cyc(3);
        req.rready <= 1'b1;
        do cyc(1); while (!rsp.rvalid);
        check8(rsp.rdata[7:0], 8'h01);
    endtask

    // ==========================================================
    // Run control
    task automatic give_verdict;
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        cyc(16);
        arst_n_i <= 1'b1;
        cyc(1);
        t_reset();
        t_line();
        t_modem();
        t_special();
        t_divisor();
        t_stall();
        give_verdict();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        cyc(5000);
        num_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
